//--- pkg/dar_pkg.sv
package dar_pkg;
  localparam int ACC_W     = 40;
  localparam int WORD_W    = 16;
  localparam int SHAMT_W   = 6;
  localparam int SIGN_BIT  = 39;
  localparam int HI_LSB    = 16;
  localparam int HI_MSB    = 31;
  localparam int CLIP_CHK  = 15;

  localparam logic [ACC_W-1:0]   ACC_RESET     = 40'h00_0000_0000;
  localparam logic [ACC_W-1:0]   ACC40_MAX_POS = 40'h7F_FFFF_FFFF;
  localparam logic [ACC_W-1:0]   ACC40_MAX_NEG = 40'h80_0000_0000;
  localparam logic [ACC_W-1:0]   ACC32_MAX_POS = 40'h00_7FFF_FFFF;
  localparam logic [ACC_W-1:0]   ACC32_MAX_NEG = 40'hFF_8000_0000;
  localparam logic [WORD_W-1:0]  WORD_MAX_POS  = 16'h7FFF;
  localparam logic [WORD_W-1:0]  WORD_MAX_NEG  = 16'h8000;
  localparam logic [WORD_W-1:0]  ROUND_HALF    = 16'h8000;
  localparam logic [WORD_W-1:0]  WB_PTR_STEP   = 16'h0002;
  localparam logic [WORD_W-1:0]  PTR_RESET     = 16'h0000;
  localparam logic [SHAMT_W-1:0] SHIFT_MAX     = 6'h10;

  typedef enum logic [1:0] {SAT_WRAP, SAT_BIT31, SAT_BIT39} dar_sat_mode_t;
  typedef enum logic [2:0] {
    CLS_MAC, CLS_MULTIPLY, CLS_NEG_MULTIPLY, CLS_DISTANCE, CLS_DISTANCE_ACC
  } dar_op_class_t;
  typedef enum logic [1:0] {WB_NONE, WB_DIRECT, WB_INDIRECT} dar_wb_mode_t;
  typedef enum logic [1:0] {SRC_ACC_A, SRC_ACC_B, SRC_XBUS} dar_shift_src_t;

  typedef struct packed {
    logic sat_enable;
    logic super_sat;
    logic round_convergent;
    logic store_clip_en;
    logic wrap_trap_en;
  } dar_ctrl_t;

  typedef struct packed {
    logic              valid;
    logic              target;
    dar_op_class_t     op_class;
    dar_wb_mode_t      wb_mode;
    logic              load;
    logic              subtract;
    logic [ACC_W-1:0]  operand;
  } dar_acc_op_t;

  typedef struct packed {
    logic              valid;
    logic              src;
    logic              rounded;
    logic [WORD_W-1:0] addr;
  } dar_store_req_t;

  typedef struct packed {
    logic               valid;
    dar_shift_src_t     src;
    logic [SHAMT_W-1:0] amount;
    logic               arith;
    logic               dsp;
    logic               target;
  } dar_shift_req_t;

  typedef struct packed {
    logic clip_a;
    logic clip_b;
    logic guard_a;
    logic guard_b;
    logic any_guard;
    logic any_clip;
  } dar_flags_t;

  typedef struct packed {
    logic              en;
    logic [WORD_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } dar_xbus_wr_t;

  typedef struct packed {
    logic [ACC_W-1:0] value;
    logic             clip;
    logic             guard;
  } dar_acc_res_t;
endpackage : dar_pkg

//--- rtl/dar_acc_backend.sv
module dar_acc_backend (
  input  logic                   CLK_SYS,
  input  logic                   RESET,
  input  logic                   CLK_EN,
  input  dar_pkg::dar_ctrl_t     CTRL,
  input  dar_pkg::dar_acc_op_t   ACC_OP,
  input  dar_pkg::dar_store_req_t STORE_REQ,
  input  dar_pkg::dar_shift_req_t SHIFT_REQ,
  input  logic [15:0]            XBUS_RD_DATA,
  input  logic [1:0]             CLIP_CLEAR,
  input  logic                   WB_PTR_WR,
  input  logic [15:0]            WB_PTR_WDATA,
  output logic [39:0]            ACC_A,
  output logic [39:0]            ACC_B,
  output dar_pkg::dar_flags_t    FLAGS,
  output logic                   ARITH_TRAP,
  output dar_pkg::dar_xbus_wr_t  XBUS_WR,
  output logic [15:0]            WB_PTR,
  output logic [39:0]            SHIFT_RESULT,
  output logic [15:0]            SHIFT_WORD,
  output logic                   SHIFT_DONE
);
  import dar_pkg::*;

  logic [ACC_W-1:0]  acc_a_reg;
  logic [ACC_W-1:0]  acc_b_reg;
  logic              clip_a_reg;
  logic              clip_b_reg;
  logic              clip_a_next;
  logic              clip_b_next;
  logic              guard_a_reg;
  logic              guard_b_reg;
  logic              trap_reg;
  logic [WORD_W-1:0] ptr_reg;
  dar_xbus_wr_t      xbus_reg;
  logic [ACC_W-1:0]  shift_res_reg;
  logic [WORD_W-1:0] shift_word_reg;
  logic              shift_done_reg;

  dar_sat_mode_t     sat_mode;
  dar_acc_res_t      res_a;
  dar_acc_res_t      res_b;
  logic              go_a;
  logic              go_b;
  logic              sh_a;
  logic              sh_b;
  logic              wb_ok;
  logic              wb_ind;
  logic [ACC_W-1:0]  wb_src;
  logic [ACC_W-1:0]  st_src;
  logic [WORD_W-1:0] wb_word;
  logic [WORD_W-1:0] st_word;
  logic [WORD_W-1:0] st_hi;
  logic [ACC_W-1:0]  sh_result;
  logic [WORD_W-1:0] sh_word;

  // One adder pass: wrap, clamp and flag in a single combinational step
  function automatic dar_acc_res_t acc_step(
    input logic [ACC_W-1:0] acc,
    input dar_acc_op_t      op,
    input dar_sat_mode_t    mode
  );
    logic [ACC_W:0] a41;
    logic [ACC_W:0] b41;
    logic [ACC_W:0] s41;
    logic           ovf39;
    logic           ovf31;
    dar_acc_res_t   r;
    a41   = op.load ? 41'h000_0000_0000 : {acc[SIGN_BIT], acc};
    b41   = {op.operand[SIGN_BIT], op.operand};
    s41   = op.subtract ? (a41 - b41) : (a41 + b41);
    ovf39 = s41[ACC_W] ^ s41[SIGN_BIT];
    ovf31 = ovf39 || (s41[SIGN_BIT:HI_MSB] != {9{s41[SIGN_BIT]}});
    r.value = s41[ACC_W-1:0];
    r.clip  = 1'b0;
    r.guard = ovf31;
    case (mode)
      SAT_BIT39: begin
        if (ovf39) begin
          r.value = s41[ACC_W] ? ACC40_MAX_NEG : ACC40_MAX_POS;
          r.clip  = 1'b1;
        end
      end
      SAT_BIT31: begin
        if (ovf31) begin
          r.value = s41[ACC_W] ? ACC32_MAX_NEG : ACC32_MAX_POS;
          r.clip  = 1'b1;
        end
        r.guard = 1'b0;
      end
      SAT_WRAP: begin
        r.clip = ovf39;
      end
      default: begin
        r.clip = ovf39;
      end
    endcase
    return r;
  endfunction : acc_step

  always_comb begin
    if (!CTRL.sat_enable) begin
      sat_mode = SAT_WRAP;
    end else if (CTRL.super_sat) begin
      sat_mode = SAT_BIT39;
    end else begin
      sat_mode = SAT_BIT31;
    end
  end

  assign go_a   = ACC_OP.valid && !ACC_OP.target;
  assign go_b   = ACC_OP.valid && ACC_OP.target;
  assign res_a  = acc_step(acc_a_reg, ACC_OP, sat_mode);
  assign res_b  = acc_step(acc_b_reg, ACC_OP, sat_mode);
  // DSP shifts land in an accumulator only when the adder leaves it alone
  assign sh_a   = SHIFT_REQ.valid && SHIFT_REQ.dsp && !SHIFT_REQ.target && !go_a;
  assign sh_b   = SHIFT_REQ.valid && SHIFT_REQ.dsp && SHIFT_REQ.target && !go_b;
  assign wb_ok  = ACC_OP.valid && ACC_OP.op_class == CLS_MAC
                  && ACC_OP.wb_mode != WB_NONE;
  assign wb_ind = wb_ok && ACC_OP.wb_mode == WB_INDIRECT && !STORE_REQ.valid;
  assign wb_src = ACC_OP.target ? acc_a_reg : acc_b_reg;
  assign st_src = STORE_REQ.src ? acc_b_reg : acc_a_reg;

  dar_round_sat u_wb_round (
    .acc_in     (wb_src),
    .round_en   (1'b1),
    .convergent (CTRL.round_convergent),
    .clip_en    (CTRL.store_clip_en),
    .hi_rounded (),
    .word_out   (wb_word)
  );

  dar_round_sat u_st_round (
    .acc_in     (st_src),
    .round_en   (STORE_REQ.rounded),
    .convergent (CTRL.round_convergent),
    .clip_en    (CTRL.store_clip_en),
    .hi_rounded (st_hi),
    .word_out   (st_word)
  );

  dar_shifter u_shift (
    .acc_a  (acc_a_reg),
    .acc_b  (acc_b_reg),
    .xdata  (XBUS_RD_DATA),
    .src    (SHIFT_REQ.src),
    .amount (SHIFT_REQ.amount),
    .arith  (SHIFT_REQ.arith),
    .result (sh_result),
    .word   (sh_word)
  );

  // Store saturation feeds only the bus; accumulators see the adder or shifter
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      acc_a_reg <= ACC_RESET;
      acc_b_reg <= ACC_RESET;
    end else if (CLK_EN) begin
      if (go_a) begin
        acc_a_reg <= res_a.value;
      end else if (sh_a) begin
        acc_a_reg <= sh_result;
      end
      if (go_b) begin
        acc_b_reg <= res_b.value;
      end else if (sh_b) begin
        acc_b_reg <= sh_result;
      end
    end
  end

  // Set beats a same-cycle software clear
  assign clip_a_next = (go_a && res_a.clip) || (clip_a_reg && !CLIP_CLEAR[0]);
  assign clip_b_next = (go_b && res_b.clip) || (clip_b_reg && !CLIP_CLEAR[1]);

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      clip_a_reg  <= 1'b0;
      clip_b_reg  <= 1'b0;
      guard_a_reg <= 1'b0;
      guard_b_reg <= 1'b0;
    end else if (CLK_EN) begin
      clip_a_reg <= clip_a_next;
      clip_b_reg <= clip_b_next;
      if (sat_mode == SAT_BIT31) begin
        guard_a_reg <= 1'b0;
        guard_b_reg <= 1'b0;
      end else begin
        if (go_a) begin
          guard_a_reg <= res_a.guard;
        end
        if (go_b) begin
          guard_b_reg <= res_b.guard;
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      trap_reg <= 1'b0;
    end else if (CLK_EN) begin
      trap_reg <= CTRL.wrap_trap_en && sat_mode == SAT_WRAP
                  && (clip_a_next || clip_b_next);
    end
  end

  // Store owns the bus in a clash; the indirect write-back is then dropped
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      xbus_reg <= '0;
    end else if (CLK_EN) begin
      xbus_reg.en <= STORE_REQ.valid || wb_ind;
      if (STORE_REQ.valid) begin
        xbus_reg.addr <= STORE_REQ.addr;
        xbus_reg.data <= st_word;
      end else if (wb_ind) begin
        xbus_reg.addr <= ptr_reg;
        xbus_reg.data <= wb_word;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ptr_reg <= PTR_RESET;
    end else if (CLK_EN) begin
      if (wb_ok && ACC_OP.wb_mode == WB_DIRECT) begin
        ptr_reg <= wb_word;
      end else if (wb_ind) begin
        ptr_reg <= ptr_reg + WB_PTR_STEP;
      end else if (WB_PTR_WR) begin
        ptr_reg <= WB_PTR_WDATA;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      shift_res_reg  <= ACC_RESET;
      shift_word_reg <= PTR_RESET;
      shift_done_reg <= 1'b0;
    end else if (CLK_EN) begin
      shift_done_reg <= SHIFT_REQ.valid;
      if (SHIFT_REQ.valid) begin
        shift_res_reg  <= sh_result;
        shift_word_reg <= sh_word;
      end
    end
  end

  assign ACC_A           = acc_a_reg;
  assign ACC_B           = acc_b_reg;
  assign FLAGS.clip_a    = clip_a_reg;
  assign FLAGS.clip_b    = clip_b_reg;
  assign FLAGS.guard_a   = guard_a_reg;
  assign FLAGS.guard_b   = guard_b_reg;
  assign FLAGS.any_guard = guard_a_reg | guard_b_reg;
  assign FLAGS.any_clip  = clip_a_reg | clip_b_reg;
  assign ARITH_TRAP      = trap_reg;
  assign XBUS_WR         = xbus_reg;
  assign WB_PTR          = ptr_reg;
  assign SHIFT_RESULT    = shift_res_reg;
  assign SHIFT_WORD      = shift_word_reg;
  assign SHIFT_DONE      = shift_done_reg;

  logic [ACC_W-1:0] sum_chk_a;
  assign sum_chk_a = acc_a_reg + ACC_OP.operand;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  sequence s_wb_indirect;
    CLK_EN && wb_ind;
  endsequence

  sequence s_bus_word;
    XBUS_WR.en && XBUS_WR.addr == $past(WB_PTR)
    && WB_PTR == $past(WB_PTR) + WB_PTR_STEP;
  endsequence

  a_clip_sticky: assert property (
    clip_a_reg && !(CLK_EN && CLIP_CLEAR[0]) |=> FLAGS.clip_a)
    else $error("clip flag A dropped without a clear");
  a_clip_set_wins: assert property (
    CLK_EN && go_b && res_b.clip && CLIP_CLEAR[1] |=> FLAGS.clip_b)
    else $error("clip flag B lost to a same-cycle clear");
  a_wrap_clip_set: assert property (
    CLK_EN && go_a && sat_mode == SAT_WRAP && !ACC_OP.load && !ACC_OP.subtract
    && acc_a_reg[39] == ACC_OP.operand[39] && sum_chk_a[39] != acc_a_reg[39]
    |=> FLAGS.clip_a && ACC_A == $past(sum_chk_a))
    else $error("wrap overflow not flagged or not wrapped");
  a_trap_raised: assert property (
    CLK_EN && clip_a_reg && !CLIP_CLEAR[0] && CTRL.wrap_trap_en
    && !CTRL.sat_enable |=> ARITH_TRAP)
    else $error("trap missing with clip flag set in wrap mode");
  a_any_flags_or: assert property (
    ##1 FLAGS.any_clip == ($past(clip_a_next) || $past(clip_b_next)) || !$past(CLK_EN))
    else $error("any_clip does not follow the clip flags");
  a_sat39_clamp: assert property (
    CLK_EN && go_a && sat_mode == SAT_BIT39 && !ACC_OP.load && !ACC_OP.subtract
    && !acc_a_reg[39] && !ACC_OP.operand[39] && sum_chk_a[39]
    |=> ACC_A == ACC40_MAX_POS ##0 FLAGS.clip_a)
    else $error("40-bit saturation value wrong");
  a_sat31_clamp: assert property (
    CLK_EN && go_b && sat_mode == SAT_BIT31 && ACC_OP.load && !ACC_OP.subtract
    && ACC_OP.operand[39] && ACC_OP.operand[38:31] != 8'hFF
    |=> ACC_B == ACC32_MAX_NEG && FLAGS.clip_b)
    else $error("32-bit negative saturation value wrong");
  a_guard_quiet: assert property (
    CLK_EN && sat_mode == SAT_BIT31 |=> !FLAGS.any_guard)
    else $error("guard flag set in 32-bit mode");
  a_wb_class: assert property (
    CLK_EN && ACC_OP.valid && ACC_OP.op_class != CLS_MAC && !STORE_REQ.valid
    |=> !XBUS_WR.en && WB_PTR == $past(WB_PTR) || $past(WB_PTR_WR))
    else $error("write-back from an excluded class");
  a_wb_direct: assert property (
    CLK_EN && wb_ok && ACC_OP.wb_mode == WB_DIRECT |=> WB_PTR == $past(wb_word))
    else $error("direct write-back word not in pointer");
  a_wb_indirect: assert property (s_wb_indirect |=> s_bus_word)
    else $error("indirect write-back address or increment wrong");
  a_round_conv: assert property (
    CLK_EN && STORE_REQ.valid && STORE_REQ.rounded && !CTRL.round_convergent
    && !CTRL.store_clip_en && st_src[15] |=> XBUS_WR.data == $past(st_src[31:16]) + 16'h0001)
    else $error("conventional round did not increment");
  a_round_even: assert property (
    CLK_EN && STORE_REQ.valid && STORE_REQ.rounded && CTRL.round_convergent
    && !CTRL.store_clip_en && st_src[16:0] == 17'h0_8000 |=> XBUS_WR.data == $past(st_src[31:16]))
    else $error("convergent round moved an even word");
  a_store_trunc: assert property (
    CLK_EN && STORE_REQ.valid && !STORE_REQ.rounded && !CTRL.store_clip_en
    |=> XBUS_WR.data == $past(st_src[31:16]))
    else $error("truncated store altered the word");
  a_acc_kept: assert property (
    CLK_EN && STORE_REQ.valid && !ACC_OP.valid && !SHIFT_REQ.valid
    |=> ACC_A == $past(ACC_A) && ACC_B == $past(ACC_B))
    else $error("store changed an accumulator");
  a_store_clip: assert property (
    CLK_EN && STORE_REQ.valid && CTRL.store_clip_en && !STORE_REQ.rounded
    && !st_src[39] && st_src[38:31] != 8'h00 |=> XBUS_WR.data == WORD_MAX_POS)
    else $error("positive store clip missing");
  a_clip_off_pass: assert property (
    CLK_EN && STORE_REQ.valid && !CTRL.store_clip_en |=> XBUS_WR.data == $past(st_hi))
    else $error("store word changed with clipping off");
  a_shift_zero: assert property (
    CLK_EN && SHIFT_REQ.valid && SHIFT_REQ.src == SRC_ACC_B && SHIFT_REQ.amount == 6'h00
    |=> SHIFT_DONE && SHIFT_RESULT == $past(ACC_B))
    else $error("zero shift changed the operand");
endmodule : dar_acc_backend

//--- rtl/dar_round_sat.sv
module dar_round_sat (
  input  logic [dar_pkg::ACC_W-1:0]  acc_in,
  input  logic                       round_en,
  input  logic                       convergent,
  input  logic                       clip_en,
  output logic [dar_pkg::WORD_W-1:0] hi_rounded,
  output logic [dar_pkg::WORD_W-1:0] word_out
);
  import dar_pkg::*;

  logic [WORD_W-1:0] lo;
  logic              inc;
  logic [23:0]       ext;

  always_comb begin
    lo  = acc_in[WORD_W-1:0];
    inc = 1'b0;
    if (round_en) begin
      if (convergent && lo == ROUND_HALF) begin
        inc = acc_in[HI_LSB];
      end else begin
        inc = lo[WORD_W-1];
      end
    end
    // Guard bits ride along so a rounding carry is seen by the clip test
    ext        = acc_in[ACC_W-1:HI_LSB] + {23'h00_0000, inc};
    hi_rounded = ext[WORD_W-1:0];
    word_out   = hi_rounded;
    if (clip_en) begin
      if (!acc_in[SIGN_BIT] && ext[23:CLIP_CHK] != 9'h000) begin
        word_out = WORD_MAX_POS;
      // A negative word that rounds up to zero wraps ext to all zeros: not an overflow
      end else if (acc_in[SIGN_BIT] && ext[23:CLIP_CHK] != 9'h1FF && ext != '0) begin
        word_out = WORD_MAX_NEG;
      end
    end
  end
endmodule : dar_round_sat

//--- rtl/dar_shifter.sv
module dar_shifter (
  input  logic [dar_pkg::ACC_W-1:0]   acc_a,
  input  logic [dar_pkg::ACC_W-1:0]   acc_b,
  input  logic [dar_pkg::WORD_W-1:0]  xdata,
  input  dar_pkg::dar_shift_src_t     src,
  input  logic [dar_pkg::SHAMT_W-1:0] amount,
  input  logic                        arith,
  output logic [dar_pkg::ACC_W-1:0]   result,
  output logic [dar_pkg::WORD_W-1:0]  word
);
  import dar_pkg::*;

  logic               left;
  logic [SHAMT_W-1:0] mag;
  logic [ACC_W-1:0]   opnd;

  always_comb begin
    left = amount[SHAMT_W-1];
    mag  = left ? (~amount + 6'h01) : amount;
    // Requests past 16 places clamp rather than wrap
    if (mag > SHIFT_MAX) begin
      mag = SHIFT_MAX;
    end
    case (src)
      SRC_ACC_A: opnd = acc_a;
      SRC_ACC_B: opnd = acc_b;
      SRC_XBUS: begin
        if (left) begin
          opnd = {24'h00_0000, xdata};
        end else begin
          opnd = {{8{arith & xdata[WORD_W-1]}}, xdata, 16'h0000};
        end
      end
      default: opnd = ACC_RESET;
    endcase
    if (left) begin
      result = opnd << mag;
    end else if (arith) begin
      result = ACC_W'($signed(opnd) >>> mag);
    end else begin
      result = opnd >> mag;
    end
    word = left ? result[WORD_W-1:0] : result[HI_MSB:HI_LSB];
  end
endmodule : dar_shifter

//--- test/dar_xbus_model.sv
module dar_xbus_model (
  input wire logic                  CLK_SYS,
  input wire dar_pkg::dar_xbus_wr_t XBUS_WR,
  input wire logic [15:0]           RD_ADDR,
  output logic [15:0]               RD_DATA
);
  timeunit 1ns;
  timeprecision 100ps;
  import dar_pkg::*;
  // Only the low address byte is kept; the bench never uses two aliasing words
  logic [15:0]  mem [256];
  logic [255:0] seen = '0;
  always @(posedge CLK_SYS) begin
    if (XBUS_WR.en) begin
      mem[XBUS_WR.addr[7:0]]  <= XBUS_WR.data;
      seen[XBUS_WR.addr[7:0]] <= 1'b1;
    end
  end
  // Unwritten words give a noise pattern, never a stale value
  always_comb begin
    RD_DATA = seen[RD_ADDR[7:0]] ? mem[RD_ADDR[7:0]] : 16'hA5A5;
  end
endmodule : dar_xbus_model

//--- test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dar_pkg::*;
  typedef struct packed {
    logic [39:0] v;
    logic cv, rd, cl;
    logic [15:0] e;
  } dar_row_t;
  logic CLK_SYS = 0, RESET = 1, CLK_EN = 1, WB_PTR_WR = 0;
  dar_ctrl_t CTRL = '0;
  dar_acc_op_t ACC_OP = '0;
  dar_store_req_t STORE_REQ = '0;
  dar_shift_req_t SHIFT_REQ = '0;
  logic [15:0] XBUS_RD_DATA, WB_PTR_WDATA = '0, WB_PTR, SHIFT_WORD, rd_addr = '0;
  logic [1:0] CLIP_CLEAR = '0;
  logic [39:0] ACC_A, ACC_B, SHIFT_RESULT;
  dar_flags_t FLAGS;
  dar_xbus_wr_t XBUS_WR;
  logic ARITH_TRAP, SHIFT_DONE;
  int n_fail = 0, n_checks = 0, cyc = 0;
  dar_row_t rows [9] = '{
    '{40'h00_1234_8000, 1'b0, 1'b1, 1'b0, 16'h1235},
    '{40'h00_1234_8000, 1'b1, 1'b1, 1'b0, 16'h1234},
    '{40'h00_1235_8000, 1'b1, 1'b1, 1'b0, 16'h1236},
    '{40'h00_1234_7FFF, 1'b0, 1'b1, 1'b0, 16'h1234},
    '{40'h00_1234_FFFF, 1'b0, 1'b0, 1'b0, 16'h1234},
    '{40'h01_0000_0000, 1'b0, 1'b0, 1'b1, 16'h7FFF},
    '{40'h01_0000_0000, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{40'hFE_0000_0000, 1'b0, 1'b0, 1'b1, 16'h8000},
    '{40'h00_7FFF_FFFF, 1'b0, 1'b1, 1'b1, 16'h7FFF}};
  always #5 CLK_SYS = ~CLK_SYS;
  dar_acc_backend dar_acc_backend_inst (.CLK_SYS(CLK_SYS), .RESET(RESET), .CLK_EN(CLK_EN),
    .CTRL(CTRL), .ACC_OP(ACC_OP), .STORE_REQ(STORE_REQ), .SHIFT_REQ(SHIFT_REQ),
    .XBUS_RD_DATA(XBUS_RD_DATA), .CLIP_CLEAR(CLIP_CLEAR), .WB_PTR_WR(WB_PTR_WR),
    .WB_PTR_WDATA(WB_PTR_WDATA), .ACC_A(ACC_A), .ACC_B(ACC_B), .FLAGS(FLAGS),
    .ARITH_TRAP(ARITH_TRAP), .XBUS_WR(XBUS_WR), .WB_PTR(WB_PTR),
    .SHIFT_RESULT(SHIFT_RESULT), .SHIFT_WORD(SHIFT_WORD), .SHIFT_DONE(SHIFT_DONE));
  dar_xbus_model dar_xbus_model_inst (.CLK_SYS(CLK_SYS), .XBUS_WR(XBUS_WR),
    .RD_ADDR(rd_addr), .RD_DATA(XBUS_RD_DATA));
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // Each request is held for exactly one rising clock edge
  task automatic acc(input logic t, input dar_op_class_t c, input dar_wb_mode_t w,
                     input logic ld, input logic sb, input logic [39:0] v);
    @(negedge CLK_SYS) ACC_OP = '{1'b1, t, c, w, ld, sb, v};
    @(negedge CLK_SYS) ACC_OP.valid = 1'b0;
  endtask : acc
  task automatic clr(input logic [1:0] m);
    @(negedge CLK_SYS) CLIP_CLEAR = m;
    @(negedge CLK_SYS) CLIP_CLEAR = 2'b00;
  endtask : clr
  task automatic shf(input dar_shift_src_t s, input logic [5:0] a, input logic ar,
                     input logic d);
    @(negedge CLK_SYS) SHIFT_REQ = '{1'b1, s, a, ar, d, 1'b1};
    @(negedge CLK_SYS) SHIFT_REQ.valid = 1'b0;
  endtask : shf
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    repeat (6) @(negedge CLK_SYS);
    RESET = 0;
    for (int i = 0; i < 9; i++) begin
      CTRL = '{1'b0, 1'b0, rows[i].cv, rows[i].cl, 1'b0};
      acc(0, CLS_MAC, WB_NONE, 1, 0, rows[i].v);
      @(negedge CLK_SYS) STORE_REQ = '{1'b1, 1'b0, rows[i].rd, 16'h0040 + 16'(i)};
      @(negedge CLK_SYS) STORE_REQ.valid = 1'b0;
      chk("store", {1'b1, 16'h0040 + 16'(i), rows[i].e}, XBUS_WR);
      chk("acc kept", rows[i].v, ACC_A);
    end
    $display("test store rounding done");
    CTRL = 5'b11000;
    clr(2'b11);
    acc(0, CLS_MAC, WB_NONE, 1, 0, ACC40_MAX_POS);
    acc(0, CLS_MAC, WB_NONE, 0, 0, 40'h00_0000_0001);
    chk("sat40 pos", {ACC40_MAX_POS, 2'b11}, {ACC_A, FLAGS.clip_a, FLAGS.any_clip});
    acc(0, CLS_MAC, WB_NONE, 1, 1, 40'h00_0000_0002);
    acc(0, CLS_MAC, WB_NONE, 0, 1, ACC40_MAX_POS);
    chk("sat40 neg", ACC40_MAX_NEG, ACC_A);
    clr(2'b01);
    chk("clip clear", 2'b00, {FLAGS.clip_a, FLAGS.any_clip});
    CTRL = 5'b10000;
    acc(1, CLS_MAC, WB_NONE, 1, 0, ACC32_MAX_POS);
    acc(1, CLS_MAC, WB_NONE, 0, 0, 40'h00_0000_0001);
    chk("sat32 pos", {ACC32_MAX_POS, 3'b100}, {ACC_B, FLAGS.clip_b, FLAGS.guard_b, FLAGS.any_guard});
    acc(1, CLS_MAC, WB_NONE, 0, 1, 40'h00_0001_0000);
    acc(1, CLS_MAC, WB_NONE, 1, 0, 40'hF0_0000_0000);
    acc(1, CLS_MAC, WB_NONE, 0, 1, 40'h00_0000_0001);
    chk("sat32 neg", ACC32_MAX_NEG, ACC_B);
    fork
      acc(1, CLS_MAC, WB_NONE, 0, 1, 40'h00_0000_0001);
      clr(2'b10);
    join
    chk("set wins", {ACC32_MAX_NEG, 1'b1}, {ACC_B, FLAGS.clip_b});
    CTRL = 5'b00001;
    clr(2'b11);
    acc(0, CLS_MAC, WB_NONE, 1, 0, ACC40_MAX_POS);
    acc(0, CLS_MAC, WB_NONE, 0, 0, 40'h00_0000_0001);
    chk("wrap", {ACC40_MAX_NEG, 4'b1111}, {ACC_A, FLAGS.clip_a, ARITH_TRAP, FLAGS.guard_a, FLAGS.any_guard});
    @(negedge CLK_SYS) chk("trap held", 1'b1, ARITH_TRAP);
    $display("test saturation done");
    CTRL = 5'b00000;
    clr(2'b11);
    acc(0, CLS_MAC, WB_NONE, 1, 0, 40'h00_4321_8000);
    @(negedge CLK_SYS) {WB_PTR_WR, WB_PTR_WDATA} = {1'b1, 16'h0100};
    @(negedge CLK_SYS) WB_PTR_WR = 1'b0;
    acc(1, CLS_MAC, WB_INDIRECT, 1, 0, 40'h00_0000_0005);
    chk("wb ind", {1'b1, 16'h0100, 16'h4322, 16'h0102}, {XBUS_WR, WB_PTR});
    acc(1, CLS_MAC, WB_DIRECT, 1, 0, 40'h00_0000_0005);
    chk("wb dir", {1'b0, 16'h4322}, {XBUS_WR.en, WB_PTR});
    for (int k = 1; k < 5; k++) begin
      acc(1, dar_op_class_t'(k), WB_INDIRECT, 1, 0, 40'h00_0000_0005);
      chk("wb none", {1'b0, 16'h4322}, {XBUS_WR.en, WB_PTR});
    end
    $display("test write-back done");
    shf(SRC_ACC_A, 6'h04, 0, 0);
    chk("shr", {1'b1, 40'h00_0432_1800, 16'h0432}, {SHIFT_DONE, SHIFT_RESULT, SHIFT_WORD});
    shf(SRC_ACC_A, 6'h3C, 0, 0);
    chk("shl", 40'h04_3218_0000, SHIFT_RESULT);
    shf(SRC_ACC_A, 6'h00, 0, 0);
    chk("sh0", 40'h00_4321_8000, SHIFT_RESULT);
    shf(SRC_ACC_B, 6'h00, 1, 0);
    chk("sh0 b", 40'h00_0000_0005, SHIFT_RESULT);
    shf(SRC_ACC_A, 6'h10, 0, 0);
    chk("sh16", 40'h00_0000_4321, SHIFT_RESULT);
    rd_addr = 16'h0047;
    shf(SRC_XBUS, 6'h04, 1, 0);
    chk("xbus shr", {40'hFF_F800_0000, 16'hF800}, {SHIFT_RESULT, SHIFT_WORD});
    rd_addr = 16'h0045;
    shf(SRC_XBUS, 6'h3C, 0, 1);
    chk("xbus shl", {40'h00_0007_FFF0, 16'hFFF0}, {ACC_B, SHIFT_WORD});
    $display("test shifter done");
    CLK_EN = 1'b0;
    acc(0, CLS_MAC, WB_NONE, 1, 0, 40'h00_0000_0077);
    chk("frozen", 40'h00_4321_8000, ACC_A);
    CLK_EN = 1'b1;
    $display("test clock enable done");
    @(negedge CLK_SYS) RESET = 1;
    @(negedge CLK_SYS) RESET = 0;
    chk("reset", '0, {ACC_A, FLAGS, WB_PTR, ARITH_TRAP, XBUS_WR.en});
    $display("test reset done");
    print_verdict();
  end
endmodule : tb
